// ---- core/mfe_front_end.sv ----
// Media front end: turns object commands into root-thread requests.
// Assumes streamer, spawner, state fetch and buffer manager run on clk.
//
// Function
// - Pass-through: one root thread per object
// - Pass-through streams inline/indirect payload to buffer
// - Base from state, index from command
// - Pointer equals base plus index times size
// - After payload, start spawner with pointer, handle
// - Thread requests go only to the spawner
// - State latched at first primitive command
// - Mode select counts as state change
// - State change allocates handles from manager
// - Handles taken strictly in ring order
// - Each thread consumes exactly one handle
// - Spawner release frees handle for reuse
// - Handle buffer holds payload and child area
// - Scan indirect and decode data take one dword per transfer
// - Scan: inline direct, indirect through scan
// - Decode mode payload from indirect bitstream
// - Scratch base and config go to spawner
// - Constant buffer handle relayed to spawner
`timescale 1ns/100ps
module mfe_front_end
    import mfe_pkg::*;
#(
    parameter int NH = `MFE_HANDLE_COUNT,
    parameter int HW = `MFE_HANDLE_W,
    parameter int PW = `MFE_PAYLOAD_W
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Command streamer
    input  wire logic              state_change,
    input  wire logic [2:0]        mode_select,
    input  wire logic              obj_valid,
    input  wire logic [31:0]       obj_desc_index,
    input  wire logic [HW-1:0]     obj_const_handle,
    input  wire logic              data_valid,
    input  wire logic              data_indirect,
    input  wire logic              data_last,
    input  wire logic [PW-1:0]     data_wide,
    output logic                   obj_ready,
    output logic                   data_ready,
    // State fetch unit
    output logic                   state_req,
    input  wire logic              state_valid,
    input  wire logic [31:0]       state_desc_base,
    input  wire logic [31:0]       state_scratch_base,
    input  wire logic [31:0]       state_scratch_cfg,
    // Global buffer manager
    output logic                   alloc_req,
    input  wire logic              alloc_valid,
    input  wire logic [HW-1:0]     alloc_handle,
    // Unified return buffer write port
    output logic                   urb_wr,
    output logic [HW-1:0]          urb_handle,
    output logic [7:0]             urb_row,
    output logic [PW-1:0]          urb_data,
    // Thread spawner
    output logic                   spawn_valid,
    input  wire logic              spawn_ready,
    output logic [31:0]            spawn_desc_ptr,
    output logic [HW-1:0]          spawn_handle,
    output logic [HW-1:0]          spawn_const_handle,
    output logic [31:0]            spawn_scratch_base,
    output logic [31:0]            spawn_scratch_cfg,
    input  wire logic              release_valid,
    input  wire logic [HW-1:0]     release_handle,
    output logic [2:0]             active_mode
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        mfe_state_t          st;
        logic [2:0]          mode;
        logic                latched;
        logic [31:0]         desc_base;
        logic [31:0]         scr_base;
        logic [31:0]         scr_cfg;
        logic [$clog2(NH):0] alloc_cnt;
        logic [31:0]         index;
        logic [HW-1:0]       cbuf;
        logic [HW-1:0]       handle;
        logic [7:0]          row;
        logic                obj_rdy;
        logic                dat_rdy;
        logic                s_req;
        logic                a_req;
        logic                wr;
        logic [PW-1:0]       wdata;
        logic                sp_vld;
        logic [31:0]         sp_ptr;
    } mfe_fe_t;
    mfe_fe_t r;
    mfe_fe_t next_r;
    logic          ring_avail;
    logic [HW-1:0] ring_head;
    logic          ring_take;
    logic          ring_clear;
    logic          scan_in;
    logic          row_valid;
    logic [PW-1:0] row_data;
    logic          pass_mode;
    // ************************************************************
    // Handle pool and per-dword operator
    // ************************************************************
    mfe_handle_ring #(
        .DEPTH          (NH),
        .W              (HW)
    ) u_ring (
        .clk            (clk),
        .rst_n          (rst_n),
        .clear          (ring_clear),
        .load           (alloc_valid && r.st == MFE_ALLOC),
        .load_handle    (alloc_handle),
        .take           (ring_take),
        .release_in     (release_valid),
        .release_handle (release_handle),
        .avail          (ring_avail),
        .head_handle    (ring_head)
    );
    // Only the low dword is fed; the wide bus narrows to the operator rate
    assign scan_in = r.st == MFE_STREAM && data_valid && r.dat_rdy && !pass_mode
                     && (data_indirect || r.mode == `MFE_MODE_VLD);
    mfe_scan_unit #(
        .PW        (PW)
    ) u_scan (
        .clk       (clk),
        .rst_n     (rst_n),
        .dw_valid  (scan_in),
        .dw_data   (data_wide[31:0]),
        .scan_sel  (r.mode == `MFE_MODE_SCAN),
        .row_valid (row_valid),
        .row_data  (row_data)
    );
    assign pass_mode  = r.mode == `MFE_MODE_PASS;
    assign ring_clear = state_change;
    assign ring_take  = r.st == MFE_SPAWN && r.sp_vld && spawn_ready;
    // ************************************************************
    // Command sequencing
    // ************************************************************
    always_comb begin
        next_r = r;
        next_r.wr = 1'b0;
        next_r.s_req = 1'b0;
        next_r.a_req = 1'b0;
        if (state_change) begin
            // New mode is state; pool is rebuilt, fetch waits for first object
            next_r.mode = mode_select;
            next_r.latched = 1'b0;
            next_r.alloc_cnt = '0;
            next_r.st = MFE_ALLOC;
            next_r.obj_rdy = 1'b0;
            next_r.dat_rdy = 1'b0;
            next_r.sp_vld = 1'b0;
        end else begin
            case (r.st)
                MFE_IDLE: begin
                    next_r.obj_rdy = 1'b1;
                    if (obj_valid && r.obj_rdy) begin
                        next_r.obj_rdy = 1'b0;
                        next_r.index = obj_desc_index;
                        next_r.cbuf = obj_const_handle;
                        next_r.st = r.latched ? MFE_WAIT_H : MFE_FETCH;
                        next_r.s_req = !r.latched;
                    end
                end
                MFE_ALLOC: begin
                    next_r.a_req = 1'b1;
                    if (alloc_valid) begin
                        next_r.alloc_cnt = r.alloc_cnt + 1'b1;
                        if (r.alloc_cnt == ($clog2(NH)+1)'(NH-1)) begin
                            next_r.a_req = 1'b0;
                            next_r.st = MFE_IDLE;
                        end
                    end
                end
                MFE_FETCH: begin
                    if (state_valid) begin
                        next_r.desc_base = state_desc_base;
                        next_r.scr_base = state_scratch_base;
                        next_r.scr_cfg = state_scratch_cfg;
                        next_r.latched = 1'b1;
                        next_r.st = MFE_WAIT_H;
                    end
                end
                MFE_WAIT_H: begin
                    if (ring_avail) begin
                        next_r.handle = ring_head;
                        next_r.row = '0;
                        next_r.dat_rdy = 1'b1;
                        next_r.st = MFE_STREAM;
                    end
                end
                MFE_STREAM: begin
                    // Payload lands in the handle's own buffer space
                    if (data_valid && r.dat_rdy) begin
                        if (pass_mode || (!data_indirect
                                && r.mode == `MFE_MODE_SCAN)) begin
                            next_r.wr = 1'b1;
                            next_r.wdata = data_wide;
                            next_r.row = r.row + 8'h01;
                        end
                        if (data_last) begin
                            next_r.dat_rdy = 1'b0;
                            next_r.st = MFE_SPAWN;
                        end
                    end
                end
                MFE_SPAWN: begin
                    if (!r.sp_vld && !r.wr && !row_valid) begin
                        next_r.sp_vld = 1'b1;
                        next_r.sp_ptr = r.desc_base
                            + 32'(r.index * `MFE_DESC_SIZE_BYTES);
                    end else if (r.sp_vld && spawn_ready) begin
                        next_r.sp_vld = 1'b0;
                        next_r.st = MFE_IDLE;
                    end
                end
                default: begin
                    next_r.st = MFE_IDLE;
                end
            endcase
            if (row_valid) begin
                next_r.wr = 1'b1;
                next_r.wdata = row_data;
                next_r.row = r.row + 8'h01;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= MFE_ALLOC;
            r.desc_base <= `MFE_RST_BASE;
            r.handle <= `MFE_RST_HANDLE;
        end else begin
            r <= next_r;
        end
    end
    // ************************************************************
    // Outputs
    // ************************************************************
    assign obj_ready  = r.obj_rdy;
    assign data_ready = r.dat_rdy;
    assign state_req  = r.s_req;
    assign alloc_req  = r.a_req;
    assign urb_wr     = r.wr;
    assign urb_handle = r.handle;
    assign urb_row    = r.row;
    assign urb_data   = r.wdata;
    // Spawner is the only exit for a thread request
    assign spawn_valid        = r.sp_vld;
    assign spawn_desc_ptr     = r.sp_ptr;
    assign spawn_handle       = r.handle;
    assign spawn_const_handle = r.cbuf;
    assign spawn_scratch_base = r.scr_base;
    assign spawn_scratch_cfg  = r.scr_cfg;
    assign active_mode        = r.mode;
endmodule

// ---- core/mfe_regs.svh ----
// Constants for the media front end: mode encodings, reset values, sizes.
// Assumes inclusion by the package and the modules that need them.
`ifndef MFE_REGS_SVH
`define MFE_REGS_SVH
// ************************************************************
// Sizes
// ************************************************************
`define MFE_DESC_SIZE_BYTES   32'd32
`define MFE_HANDLE_COUNT      8
`define MFE_HANDLE_W          8
`define MFE_PTR_W             32
`define MFE_PAYLOAD_W         256
// ************************************************************
// Mode encodings
// ************************************************************
`define MFE_MODE_PASS         3'h0
`define MFE_MODE_SCAN         3'h1
`define MFE_MODE_VLD          3'h2
// ************************************************************
// Reset values
// ************************************************************
`define MFE_RST_BASE          32'h0000_0000
`define MFE_RST_HANDLE        8'h00
`endif

// ---- core/mfe_pkg.sv ----
// Types shared by the media front end modules.
// Assumes mfe_regs.svh sits on the include path.
`include "mfe_regs.svh"
package mfe_pkg;
    typedef enum logic [5:0] {
        MFE_IDLE   = 6'b000001,
        MFE_ALLOC  = 6'b000010,
        MFE_WAIT_H = 6'b000100,
        MFE_STREAM = 6'b001000,
        MFE_SPAWN  = 6'b010000,
        MFE_FETCH  = 6'b100000
    } mfe_state_t;
endpackage

// ---- core/mfe_handle_ring.sv ----
// Circular pool of return buffer handles with in-order take.
// Assumes handles are loaded after a state change; releases may come out of order.
`timescale 1ns/100ps
`include "mfe_regs.svh"
module mfe_handle_ring #(
    parameter int DEPTH = `MFE_HANDLE_COUNT,
    parameter int W     = `MFE_HANDLE_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clear,
    input  wire logic         load,
    input  wire logic [W-1:0] load_handle,
    input  wire logic         take,
    input  wire logic         release_in,
    input  wire logic [W-1:0] release_handle,
    output logic              avail,
    output logic [W-1:0]      head_handle
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] slot;
        logic [DEPTH-1:0]        busy;
        logic [DEPTH-1:0]        used;
        logic [AW-1:0]           head;
        logic [AW-1:0]           fill;
        logic [W-1:0]            out;
    } mfe_ring_t;
    mfe_ring_t r;
    mfe_ring_t next_r;
    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.used = '0;
            next_r.busy = '0;
            next_r.fill = '0;
            next_r.head = '0;
        end else begin
            if (load && !r.used[r.fill]) begin
                next_r.slot[r.fill] = load_handle;
                next_r.used[r.fill] = 1'b1;
                next_r.fill = AW'(r.fill + 1'b1);
            end
            // Release may free any slot; a take always moves the head
            for (int i = 0; i < DEPTH; i++) begin
                if (release_in && r.used[i] && r.slot[i] == release_handle) begin
                    next_r.busy[i] = 1'b0;
                end
            end
            if (take) begin
                next_r.busy[r.head] = 1'b1;
                next_r.head = AW'(r.head + 1'b1);
            end
        end
        next_r.out = next_r.slot[next_r.head];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    // Strict order: a free slot behind a busy head still waits
    assign avail       = r.used[r.head] && !r.busy[r.head];
    assign head_handle = r.out;
endmodule

// ---- core/mfe_scan_unit.sv ----
// Per-double-word operator for the scan and decode modes.
// Assumes one double word per valid; packs eight into a payload row.
`timescale 1ns/100ps
`include "mfe_regs.svh"
module mfe_scan_unit #(
    parameter int PW = `MFE_PAYLOAD_W
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          dw_valid,
    input  wire logic [31:0]   dw_data,
    input  wire logic          scan_sel,
    output logic               row_valid,
    output logic [PW-1:0]      row_data
);
    localparam int N = PW / 32;
    typedef struct packed {
        logic [PW-1:0]          acc;
        logic [$clog2(N)-1:0]   cnt;
        logic                   vld;
        logic [PW-1:0]          outd;
    } mfe_scan_s_t;
    mfe_scan_s_t s;
    mfe_scan_s_t next_s;
    // Simple reordering stand-in: scan reverses halves, decode passes bits
    function automatic logic [31:0] mfe_op(input logic [31:0] d, input logic sc);
        mfe_op = sc ? {d[15:0], d[31:16]} : d;
    endfunction
    always_comb begin
        next_s = s;
        next_s.vld = 1'b0;
        if (dw_valid) begin
            next_s.acc[s.cnt*32 +: 32] = mfe_op(dw_data, scan_sel);
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt == N-1) begin
                next_s.vld  = 1'b1;
                next_s.outd = next_s.acc;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign row_valid = s.vld;
    assign row_data  = s.outd;
endmodule

// ---- sim/mfe_far_model.sv ----
// Far side of the front end: state fetch, handle manager and spawner.
// Assumes the front end's clk and rst_n; the bench steers release pace.
`timescale 1ns/100ps
module mfe_far_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        state_req,
    input  wire logic [31:0] st_base,
    input  wire logic        alloc_req,
    input  wire logic [7:0]  hbase,
    input  wire logic        spawn_valid,
    input  wire logic [7:0]  spawn_handle,
    input  wire logic        hold_rel,
    output logic             state_valid,
    output logic [31:0]      state_desc_base,
    output logic [31:0]      state_scratch_base,
    output logic [31:0]      state_scratch_cfg,
    output logic             alloc_valid,
    output logic [7:0]       alloc_handle,
    output logic             spawn_ready,
    output logic             release_valid,
    output logic [7:0]       release_handle
);
    logic [3:0] acnt;
    logic [2:0] dly;
    logic [7:0] q [$];
    // ************************************************************
    // Model
    // ************************************************************
    // Idle data shows the inverse, so a stale sample cannot pass
    assign state_desc_base    = state_valid ? st_base : ~st_base;
    assign state_scratch_base = state_valid ? 32'h00ab_0000 : 32'hff54_ffff;
    assign state_scratch_cfg  = state_valid ? 32'h0000_0013 : 32'hffff_ffec;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {state_valid, alloc_valid, spawn_ready, release_valid, acnt, dly} <= '0;
            {alloc_handle, release_handle} <= '0;
            q.delete();
        end else begin
            state_valid <= state_req;
            {alloc_valid, release_valid} <= 2'b00;
            {alloc_handle, release_handle} <= ~{alloc_handle, release_handle};
            if (!alloc_req)
                acnt <= 4'h0;
            else if (!alloc_valid && acnt < 4'h8) begin
                {alloc_valid, alloc_handle} <= {1'b1, hbase + 8'(acnt)};
                acnt <= acnt + 4'h1;
            end
            // Slow answers while releases held
            spawn_ready <= spawn_valid && !spawn_ready && dly >= {hold_rel, 2'b00};
            dly <= (spawn_valid && !spawn_ready) ? dly + 3'h1 : 3'h0;
            if (spawn_valid && spawn_ready) q.push_back(spawn_handle);
            // Newest first: ring sees out-of-order releases
            if (!hold_rel && !release_valid && q.size() > 0) begin
                {release_valid, release_handle} <= {1'b1, q.pop_back()};
            end
        end
    end
endmodule

// ---- sim/mfe_front_end_properties.sv ----
// Checker for the front end's command and spawn handshakes.
// Assumes a bind to mfe_front_end; sees only its ports.
`timescale 1ns/100ps
module mfe_front_end_properties #(
    parameter int HW = 8
) (
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          state_change,
    input wire logic [2:0]    mode_select,
    input wire logic          obj_valid,
    input wire logic          obj_ready,
    input wire logic [31:0]   obj_desc_index,
    input wire logic [HW-1:0] obj_const_handle,
    input wire logic          state_req,
    input wire logic          state_valid,
    input wire logic [31:0]   state_desc_base,
    input wire logic [31:0]   state_scratch_base,
    input wire logic          spawn_valid,
    input wire logic          spawn_ready,
    input wire logic [31:0]   spawn_desc_ptr,
    input wire logic [HW-1:0] spawn_handle,
    input wire logic [HW-1:0] spawn_const_handle,
    input wire logic [31:0]   spawn_scratch_base,
    input wire logic [2:0]    active_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0]   base_q, idx_q, sb_q;
    logic [HW-1:0] ch_q;
    logic [2:0]    mode_q;
    logic [1:0]    pend;
    logic          first;
    wire take = obj_valid && obj_ready;
    wire acc  = spawn_valid && spawn_ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {base_q, idx_q, sb_q, ch_q, mode_q, pend} <= '0;
            first <= 1'b1;
        end else begin
            if (state_valid) {base_q, sb_q} <= {state_desc_base, state_scratch_base};
            if (take) {idx_q, ch_q} <= {obj_desc_index, obj_const_handle};
            if (state_change) mode_q <= mode_select;
            first <= state_change || (first && !take);
            pend <= pend + 2'(take) - 2'(acc);
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    chk_desc_ptr: assert property (spawn_valid |-> spawn_desc_ptr == base_q + idx_q * 32)
        else $error("descriptor pointer wrong");
    chk_spawn_hold: assert property (spawn_valid && !spawn_ready |=>
        spawn_valid && $stable(spawn_desc_ptr) && $stable(spawn_handle))
        else $error("spawn request changed before accept");
    chk_one_thread: assert property (acc |-> pend == 2'd1)
        else $error("spawn without exactly one object");
    chk_const_relay: assert property (spawn_valid |-> spawn_const_handle == ch_q)
        else $error("constant handle not relayed");
    chk_scratch_fwd: assert property (spawn_valid |-> spawn_scratch_base == sb_q)
        else $error("scratch base not forwarded");
    chk_fetch_first: assert property (take && first |=> state_req)
        else $error("no state fetch at first object");
    chk_obj_drop: assert property (take |=> !obj_ready [*2])
        else $error("object taken while thread open");
    chk_mode_track: assert property (state_change |=> ##[0:1] active_mode == mode_q)
        else $error("mode not taken at state change");
    cover property (take && first);
    cover property (spawn_valid && !spawn_ready ##1 acc);
    cover property (state_change && mode_select == 3'h2);
endmodule
bind mfe_front_end mfe_front_end_properties #(.HW(HW)) chk_u (.clk, .rst_n, .state_change,
    .mode_select, .obj_valid, .obj_ready, .obj_desc_index, .obj_const_handle, .state_req,
    .state_valid, .state_desc_base, .state_scratch_base, .spawn_valid, .spawn_ready,
    .spawn_desc_ptr, .spawn_handle, .spawn_const_handle, .spawn_scratch_base, .active_mode);

// ---- sim/test_media_front_end_thread_gen.sv ----
// Bench for the front end: pass-through, state latch, handle stall, scan, decode.
// Assumes the design, mfe_far_model and the bound checker are compiled first.
`timescale 1ns/100ps
module test_media_front_end_thread_gen;
    logic         clk = 1'b0, rst_n = 1'b0, state_change = 1'b0, obj_valid = 1'b0;
    logic         data_valid = 1'b0, data_indirect = 1'b0, data_last = 1'b0, hold_rel = 1'b0;
    logic [2:0]   mode_select = 3'h0;
    logic [7:0]   obj_const_handle = 8'h00, hbase = 8'h10, sp_h, sp_ch, row_h;
    logic [31:0]  obj_desc_index = '0, st_base = 32'h0001_0000, eb = 32'h0001_0000;
    logic [31:0]  sp_ptr, sp_sb, sp_cfg;
    logic [255:0] data_wide = '0, row;
    wire logic    obj_ready, data_ready, state_req, state_valid, alloc_req, alloc_valid;
    wire logic    urb_wr, spawn_valid, spawn_ready, release_valid;
    wire logic [2:0]   active_mode;
    wire logic [7:0]   alloc_handle, urb_handle, urb_row, spawn_handle, spawn_const_handle;
    wire logic [7:0]   release_handle;
    wire logic [31:0]  state_desc_base, state_scratch_base, state_scratch_cfg, spawn_desc_ptr;
    wire logic [31:0]  spawn_scratch_base, spawn_scratch_cfg;
    wire logic [255:0] urb_data;
    int errors = 0, compares = 0, nsp = 0, hs = 0;
    mfe_front_end dut_u (.clk, .rst_n, .state_change, .mode_select, .obj_valid, .obj_desc_index,
        .obj_const_handle, .data_valid, .data_indirect, .data_last, .data_wide, .obj_ready,
        .data_ready, .state_req, .state_valid, .state_desc_base, .state_scratch_base,
        .state_scratch_cfg, .alloc_req, .alloc_valid, .alloc_handle, .urb_wr, .urb_handle,
        .urb_row, .urb_data, .spawn_valid, .spawn_ready, .spawn_desc_ptr, .spawn_handle,
        .spawn_const_handle, .spawn_scratch_base, .spawn_scratch_cfg, .release_valid,
        .release_handle, .active_mode);
    mfe_far_model far_u (.clk, .rst_n, .state_req, .st_base, .alloc_req, .hbase, .spawn_valid,
        .spawn_handle, .hold_rel, .state_valid, .state_desc_base, .state_scratch_base,
        .state_scratch_cfg, .alloc_valid, .alloc_handle, .spawn_ready, .release_valid,
        .release_handle);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        if (urb_wr) {row, row_h} <= {urb_data, urb_handle};
        if (spawn_valid && spawn_ready) begin
            nsp <= nsp + 1;
            {sp_ptr, sp_h, sp_ch} <= {spawn_desc_ptr, spawn_handle, spawn_const_handle};
            {sp_sb, sp_cfg} <= {spawn_scratch_base, spawn_scratch_cfg};
        end
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input string nm, input logic [255:0] got, input logic [255:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run_obj(input logic [31:0] idx, input int nb, input logic ind,
                           input logic [31:0] d0, input logic [255:0] er);
        int t = 0;
        int n0 = nsp;
        obj_valid <= 1'b1;
        obj_desc_index <= idx;
        obj_const_handle <= idx[7:0] ^ 8'h5a;
        do @(posedge clk); while (!obj_ready && ++t < 300);
        obj_valid <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            {data_valid, data_indirect, data_last} <= {1'b1, ind, i == nb - 1};
            data_wide <= {8{d0 + 32'(i)}};
            do @(posedge clk); while (!data_ready && ++t < 300);
        end
        {data_valid, data_last} <= 2'b00;
        while (nsp == n0 && ++t < 300) @(posedge clk);
        chk("spawn count", 256'(nsp), 256'(n0 + 1));
        chk("handle", sp_h, hbase + 8'(hs));
        chk("payload handle", row_h, sp_h);
        chk("payload row", row, er);
        chk("descriptor", sp_ptr, 32'(eb + idx * 32));
        chk("scratch", {sp_sb, sp_cfg}, {32'h00ab_0000, 32'h0000_0013});
        chk("constant handle", sp_ch, idx[7:0] ^ 8'h5a);
        hs = (hs + 1) % 8;
    endtask
    task automatic newstate(input logic [2:0] m, input logic [7:0] hb);
        int t = 0;
        repeat (20) @(posedge clk);
        {state_change, mode_select, hbase} <= {1'b1, m, hb};
        @(posedge clk);
        state_change <= 1'b0;
        hs = 0;
        repeat (2) @(posedge clk);
        do @(posedge clk); while (!obj_ready && ++t < 300);
        chk("active mode", active_mode, m);
    endtask
    task t_pass;
        for (int k = 0; k < 4; k++)
            run_obj(k == 3 ? 32'h07ff_ffff : 32'(k * 5), 1 + k % 2, 1'(k % 2),
                    32'h1111_1111 * 32'(k), {8{32'h1111_1111 * 32'(k) + 32'(k % 2)}});
        $display("test pass-through done");
    endtask
    task t_latch;
        st_base <= 32'h0004_0000;
        newstate(3'h0, 8'h20);
        st_base <= 32'h0008_0000;
        eb = 32'h0008_0000;
        run_obj(32'd3, 1, 1'b0, 32'h00c0_ffee, {8{32'h00c0_ffee}});
        $display("test state latch done");
    endtask
    task t_stall;
        int n;
        hold_rel <= 1'b1;
        for (int k = 0; k < 8; k++)
            run_obj(32'(k), 1, 1'b0, 32'(k), {8{32'(k)}});
        n = nsp;
        fork
            run_obj(32'd9, 1, 1'b0, 32'h9, {8{32'h9}});
            begin
                repeat (40) @(posedge clk);
                chk("stalled spawn", 256'(nsp), 256'(n));
                hold_rel <= 1'b0;
            end
        join
        $display("test handle stall done");
    endtask
    task t_modes;
        logic [255:0] sw, pl;
        for (int i = 0; i < 8; i++) begin
            sw[32 * i +: 32] = {16'(32'h0c00 + i), 16'h0a0b};
            pl[32 * i +: 32] = 32'h0a0b_0c00 + 32'(i);
        end
        newstate(3'h1, 8'h30);
        run_obj(32'd2, 8, 1'b1, 32'h0a0b_0c00, sw);
        run_obj(32'd4, 1, 1'b0, 32'h0505_0505, {8{32'h0505_0505}});
        newstate(3'h2, 8'h40);
        run_obj(32'd6, 8, 1'b1, 32'h0a0b_0c00, pl);
        $display("test scan and decode done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge clk);
        t_pass;
        t_latch;
        t_stall;
        t_modes;
        close_out;
    end
    // A hang counts against the run
    initial begin
        #500000;
        errors++;
        close_out;
    end
endmodule
